// ===== logic/ddr_pins_regs.svh
// Summary of operation
// - drive the 16-bit row or column address to the memory
// - drive 3-bit bank select naming the bank of each command
// - memory clock leaves as a true and complement pair
// - clock enable follows clkEnable; the memory clock pair toggles at either level
// - two active-low chip selects, low selects the rank addressed
// - low mask covers data bits 7:0, high mask bits 15:8 on writes
// - strobes follow data direction; on writes the controller drives them
// - on reads memory drives strobes edge-aligned; controller captures with them
// - low strobe pair times bits 7:0, high pair bits 15:8
// - row, column and write strobes with chip selects encode each command
// - a dedicated output switches memory on-die termination
`ifndef DDR_PINS_REGS_SVH
`define DDR_PINS_REGS_SVH

// ==========================================================
// timing
`define SYS_CLK_MHZ 50
`define MEM_CLK_NS 160
`define MEM_CLK_CYC ((`MEM_CLK_NS * `SYS_CLK_MHZ) / 1000)
`define RD_TIMEOUT_NS 1280
`define RD_TIMEOUT_CYC ((`RD_TIMEOUT_NS * `SYS_CLK_MHZ) / 1000)

// ==========================================================
// phase points within one memory clock period
`define PH_LAST 3'h7
`define PH_FALL_PRE 3'h3
`define PH_WR_START 3'h5
`define PH_BEAT1_PRE 3'h1
`define PH_ZERO 3'h0

// ==========================================================
// command codes {row, col, write}
`define CODE_NOP 3'h7
`define CODE_ACT 3'h3
`define CODE_RD 3'h5
`define CODE_WR 3'h4
`define CODE_PRE 3'h2
`define CODE_REF 3'h1
`define CODE_MRS 3'h0
`define CODE_ZQ 3'h6
`define RANK_NONE 2'h3

`endif

// ===== logic/ddr_pins_pkg.sv
`default_nettype none
`include "ddr_pins_regs.svh"
package ddr_pins_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS,
    CMD_ZQ} cmd_e;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} state_e;

  function automatic logic [2:0] cmd_code(input cmd_e kind);
    case (kind)
      CMD_ACT: cmd_code = `CODE_ACT;
      CMD_RD: cmd_code = `CODE_RD;
      CMD_WR: cmd_code = `CODE_WR;
      CMD_PRE: cmd_code = `CODE_PRE;
      CMD_REF: cmd_code = `CODE_REF;
      CMD_MRS: cmd_code = `CODE_MRS;
      CMD_ZQ: cmd_code = `CODE_ZQ;
      default: cmd_code = `CODE_NOP;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== logic/ddr_lane_capture.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_lane_capture (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  // strobe pair and data from pins
  input wire logic strobeTrue,
  input wire logic strobeComp,
  input wire logic [7:0] laneData,
  // captured beats
  output logic [15:0] beats,
  output logic done
);
  logic [1:0] trueSync_reg;
  logic [1:0] compSync_reg;
  logic [7:0] dataSync1_reg;
  logic [7:0] dataSync2_reg;
  logic level_reg;
  logic gotRise_reg;
  logic rise;
  logic fall;

  // ==========================================================
  // two-stage synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trueSync_reg <= 2'h0;
      compSync_reg <= 2'h3;
      dataSync1_reg <= 8'h00;
      dataSync2_reg <= 8'h00;
    end else begin
      trueSync_reg <= {trueSync_reg[0], strobeTrue};
      compSync_reg <= {compSync_reg[0], strobeComp};
      dataSync1_reg <= laneData;
      dataSync2_reg <= dataSync1_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= trueSync_reg[1] & ~compSync_reg[1];
    end
  end

  assign rise = ~level_reg & trueSync_reg[1] & ~compSync_reg[1];
  assign fall = level_reg & ~trueSync_reg[1] & compSync_reg[1];

  // ==========================================================
  // beat capture: rising edge beat 0, falling edge beat 1
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      beats <= 16'h0000;
      gotRise_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        gotRise_reg <= 1'b0;
      end else if (rise) begin
        beats[7:0] <= dataSync2_reg;
        gotRise_reg <= 1'b1;
      end else if (fall && gotRise_reg) begin
        beats[15:8] <= dataSync2_reg;
        gotRise_reg <= 1'b0;
        done <= 1'b1;
      end
    end
  end

  lane_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done |-> $past(fall) && $past(enable))
    else $error("lane done without strobe fall");
endmodule
`default_nettype wire

// ===== logic/ddr_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_pins_regs.svh"
module ddr_pin_interface (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // command request
  input wire logic cmdValid,
  output logic cmdReady,
  input wire ddr_pins_pkg::cmd_e cmdKind,
  input wire logic cmdRank,
  input wire logic [2:0] cmdBank,
  input wire logic [15:0] cmdAddr,
  input wire logic [31:0] wrData,
  input wire logic [3:0] wrMask,
  // levels
  input wire logic clkEnable,
  input wire logic termOn,
  // read answer
  output logic rdValid,
  output logic [31:0] rdData,
  output logic rdTimeout,
  // memory clock and command pins
  output logic mem_clk_true,
  output logic mem_clk_comp,
  output logic mem_clk_en,
  output logic [1:0] mem_rank_sel_n,
  output logic mem_row_strobe_n,
  output logic mem_col_strobe_n,
  output logic mem_write_en_n,
  output logic [2:0] mem_bank,
  output logic [15:0] mem_addr,
  output logic mem_term_ctrl,
  // data and masks
  input wire logic [15:0] mem_data_in,
  output logic [15:0] mem_data_out,
  output logic mem_data_oe_n,
  output logic mem_mask_low,
  output logic mem_mask_high,
  // strobes
  input wire logic mem_strobe_low_true_in,
  input wire logic mem_strobe_low_comp_in,
  input wire logic mem_strobe_high_true_in,
  input wire logic mem_strobe_high_comp_in,
  output logic mem_strobe_low_true_out,
  output logic mem_strobe_low_comp_out,
  output logic mem_strobe_high_true_out,
  output logic mem_strobe_high_comp_out,
  output logic mem_strobe_oe_n
);
  ddr_pins_pkg::state_e state_reg;
  logic [2:0] phase_reg;
  logic [31:0] wrData_reg;
  logic [3:0] wrMask_reg;
  logic wrStep_reg;
  logic [7:0] rdWait_reg;
  logic issue;
  logic atFall;
  logic lowDone_reg;
  logic highDone_reg;
  logic lowDone;
  logic highDone;
  logic [15:0] lowBeats;
  logic [15:0] highBeats;
  logic capEnable;
  logic strobeLevel;

  // ==========================================================
  // memory clock divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= `PH_ZERO;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_clk_true <= 1'b1;
      mem_clk_comp <= 1'b0;
    end else if (phase_reg == `PH_LAST) begin
      mem_clk_true <= 1'b1;
      mem_clk_comp <= 1'b0;
    end else if (phase_reg == `PH_FALL_PRE) begin
      mem_clk_true <= 1'b0;
      mem_clk_comp <= 1'b1;
    end
  end

  assign atFall = phase_reg == `PH_FALL_PRE;
  assign cmdReady = atFall && state_reg == ddr_pins_pkg::ST_IDLE;
  assign issue = cmdReady && cmdValid;

  // ==========================================================
  // command, address and bank launch on the falling true edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rank_sel_n <= `RANK_NONE;
      {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} <= `CODE_NOP;
      mem_bank <= 3'h0;
      mem_addr <= 16'h0000;
    end else if (atFall) begin
      if (issue && cmdKind != ddr_pins_pkg::CMD_NOP) begin
        mem_rank_sel_n <= cmdRank ? 2'h1 : 2'h2;
        {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} <=
          ddr_pins_pkg::cmd_code(cmdKind);
        mem_bank <= cmdBank;
        mem_addr <= cmdAddr;
      end else begin
        mem_rank_sel_n <= `RANK_NONE;
        {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} <= `CODE_NOP;
      end
    end
  end

  // ==========================================================
  // clock enable and termination levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_clk_en <= 1'b0;
      mem_term_ctrl <= 1'b0;
    end else if (atFall) begin
      mem_clk_en <= clkEnable;
      mem_term_ctrl <= termOn;
    end
  end

  // ==========================================================
  // transfer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ddr_pins_pkg::ST_IDLE;
      wrData_reg <= 32'h00000000;
      wrMask_reg <= 4'h0;
    end else begin
      case (state_reg)
        ddr_pins_pkg::ST_IDLE: begin
          if (issue && cmdKind == ddr_pins_pkg::CMD_WR) begin
            state_reg <= ddr_pins_pkg::ST_WRITE;
            wrData_reg <= wrData;
            wrMask_reg <= wrMask;
          end else if (issue && cmdKind == ddr_pins_pkg::CMD_RD) begin
            state_reg <= ddr_pins_pkg::ST_READ;
          end
        end
        ddr_pins_pkg::ST_WRITE: begin
          if (phase_reg == `PH_WR_START && wrStep_reg) begin
            state_reg <= ddr_pins_pkg::ST_IDLE;
          end
        end
        ddr_pins_pkg::ST_READ: begin
          if ((lowDone_reg && highDone_reg) || rdWait_reg == 8'(`RD_TIMEOUT_CYC)) begin
            state_reg <= ddr_pins_pkg::ST_IDLE;
          end
        end
        default: state_reg <= ddr_pins_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // write data, masks and strobes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrStep_reg <= 1'b0;
      mem_data_out <= 16'h0000;
      mem_data_oe_n <= 1'b1;
      mem_mask_low <= 1'b0;
      mem_mask_high <= 1'b0;
      strobeLevel <= 1'b0;
      mem_strobe_oe_n <= 1'b1;
    end else if (state_reg == ddr_pins_pkg::ST_WRITE) begin
      if (phase_reg == `PH_WR_START && !wrStep_reg) begin
        wrStep_reg <= 1'b1;
        mem_data_out <= wrData_reg[15:0];
        {mem_mask_high, mem_mask_low} <= wrMask_reg[1:0];
        mem_data_oe_n <= 1'b0;
        mem_strobe_oe_n <= 1'b0;
        strobeLevel <= 1'b0;
      end else if (phase_reg == `PH_LAST) begin
        strobeLevel <= 1'b1;
      end else if (phase_reg == `PH_BEAT1_PRE) begin
        mem_data_out <= wrData_reg[31:16];
        {mem_mask_high, mem_mask_low} <= wrMask_reg[3:2];
      end else if (phase_reg == `PH_FALL_PRE) begin
        strobeLevel <= 1'b0;
      end else if (phase_reg == `PH_WR_START && wrStep_reg) begin
        wrStep_reg <= 1'b0;
        mem_data_oe_n <= 1'b1;
        mem_strobe_oe_n <= 1'b1;
        {mem_mask_high, mem_mask_low} <= 2'h0;
      end
    end else begin
      wrStep_reg <= 1'b0;
      mem_data_oe_n <= 1'b1;
      mem_strobe_oe_n <= 1'b1;
      {mem_mask_high, mem_mask_low} <= 2'h0;
    end
  end

  assign mem_strobe_low_true_out = strobeLevel;
  assign mem_strobe_low_comp_out = ~strobeLevel;
  assign mem_strobe_high_true_out = strobeLevel;
  assign mem_strobe_high_comp_out = ~strobeLevel;

  // ==========================================================
  // read capture, one lane per strobe pair
  assign capEnable = state_reg == ddr_pins_pkg::ST_READ;

  ddr_lane_capture lowLane (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(capEnable),
    .strobeTrue(mem_strobe_low_true_in),
    .strobeComp(mem_strobe_low_comp_in),
    .laneData(mem_data_in[7:0]),
    .beats(lowBeats),
    .done(lowDone)
  );

  ddr_lane_capture highLane (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(capEnable),
    .strobeTrue(mem_strobe_high_true_in),
    .strobeComp(mem_strobe_high_comp_in),
    .laneData(mem_data_in[15:8]),
    .beats(highBeats),
    .done(highDone)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowDone_reg <= 1'b0;
      highDone_reg <= 1'b0;
      rdWait_reg <= 8'h00;
      rdValid <= 1'b0;
      rdTimeout <= 1'b0;
      rdData <= 32'h00000000;
    end else begin
      rdValid <= 1'b0;
      rdTimeout <= 1'b0;
      if (capEnable) begin
        lowDone_reg <= lowDone_reg | lowDone;
        highDone_reg <= highDone_reg | highDone;
        rdWait_reg <= rdWait_reg + 8'h01;
        if (lowDone_reg && highDone_reg) begin
          rdValid <= 1'b1;
          rdData <= {highBeats[15:8], lowBeats[15:8], highBeats[7:0], lowBeats[7:0]};
        end else if (rdWait_reg == 8'(`RD_TIMEOUT_CYC)) begin
          rdTimeout <= 1'b1;
        end
      end else begin
        lowDone_reg <= 1'b0;
        highDone_reg <= 1'b0;
        rdWait_reg <= 8'h00;
      end
    end
  end

  // ==========================================================
  // checks
  clk_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mem_clk_comp == !mem_clk_true)
    else $error("memory clock pair not complementary");

  cmd_at_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed({mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n, mem_addr, mem_bank})
    |-> $fell(mem_clk_true))
    else $error("command changed away from falling clock");

  cke_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEnable && atFall) |=> mem_clk_en ##1 mem_clk_en [*3])
    else $error("clock enable did not follow request");

  rank_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $countones(mem_rank_sel_n) >= 1)
    else $error("both ranks selected");

  desel_nop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_rank_sel_n == `RANK_NONE) |->
      {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} == `CODE_NOP)
    else $error("command pins active while deselected");

  bank_issue_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (issue && cmdKind == ddr_pins_pkg::CMD_ACT) |=> mem_bank == $past(cmdBank)
      && mem_addr == $past(cmdAddr) && mem_row_strobe_n == 1'b0)
    else $error("activate not launched with its bank");

  wr_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mem_strobe_oe_n |-> $past(state_reg) == ddr_pins_pkg::ST_WRITE && !mem_data_oe_n)
    else $error("strobes driven outside write");

  wr_burst_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(mem_data_oe_n) |-> !mem_data_oe_n [*8] ##1 mem_data_oe_n)
    else $error("write burst length wrong");

  odt_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    atFall |=> mem_term_ctrl == $past(termOn))
    else $error("termination not following request");

  rd_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(capEnable) |-> ##[1:70] (rdValid || rdTimeout))
    else $error("read neither answered nor timed out");

  write_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(mem_strobe_oe_n));
  read_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n) rdValid);
  timeout_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n) rdTimeout);
  cke_off_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(mem_clk_en));
endmodule
`default_nettype wire

// ===== dv/ddr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_mem_model (
  // command pins
  input wire logic mem_clk_true,
  input wire logic [1:0] mem_rank_sel_n,
  input wire logic mem_row_strobe_n,
  input wire logic mem_col_strobe_n,
  input wire logic mem_write_en_n,
  input wire logic [15:0] mem_addr,
  // controller side of data and strobes
  input wire logic [15:0] mem_data_out,
  input wire logic mem_data_oe_n,
  input wire logic mem_mask_low,
  input wire logic mem_mask_high,
  input wire logic mem_strobe_low_true_out,
  input wire logic mem_strobe_low_comp_out,
  input wire logic mem_strobe_high_true_out,
  input wire logic mem_strobe_high_comp_out,
  input wire logic mem_strobe_oe_n,
  // resolved wires
  output logic [15:0] mem_data_in,
  output logic mem_strobe_low_true_in,
  output logic mem_strobe_low_comp_in,
  output logic mem_strobe_high_true_in,
  output logic mem_strobe_high_comp_in,
  // test control and captured write
  input wire logic mute,
  input wire logic slow,
  output logic [31:0] wrBeats,
  output logic [3:0] wrMasks
);
  logic memDrive = 1'b0;
  logic memStrobe = 1'b0;
  logic [15:0] memData = 16'h0;
  logic [15:0] lastData = 16'h0;
  logic strobeLow;
  logic strobeHigh;
  logic lowSeen = 1'b0;
  logic highSeen = 1'b0;

  // ==========================================================
  // wire resolution: a released bus shows the inverse of its last value
  always @(mem_data_oe_n or mem_data_out or memDrive or memData) begin
    if (!mem_data_oe_n)
      lastData = mem_data_out;
    else if (memDrive)
      lastData = memData;
  end
  assign mem_data_in = !mem_data_oe_n ? mem_data_out : (memDrive ? memData : ~lastData);
  // released strobes parked true low by termination
  assign strobeLow = !mem_strobe_oe_n ? mem_strobe_low_true_out : (memDrive & memStrobe);
  assign strobeHigh = !mem_strobe_oe_n ? mem_strobe_high_true_out : (memDrive & memStrobe);
  assign mem_strobe_low_true_in = strobeLow;
  assign mem_strobe_high_true_in = strobeHigh;
  assign mem_strobe_low_comp_in = !mem_strobe_oe_n ? mem_strobe_low_comp_out : ~strobeLow;
  assign mem_strobe_high_comp_in = !mem_strobe_oe_n ? mem_strobe_high_comp_out : ~strobeHigh;

  // ==========================================================
  // write capture, each lane on its own strobe
  always @(strobeLow or strobeHigh) begin
    if (!mem_strobe_oe_n && strobeLow != lowSeen) begin
      if (strobeLow) begin
        {wrMasks[0], wrBeats[7:0]} <= {mem_mask_low, mem_data_in[7:0]};
      end else begin
        {wrMasks[2], wrBeats[23:16]} <= {mem_mask_low, mem_data_in[7:0]};
      end
    end
    if (!mem_strobe_oe_n && strobeHigh != highSeen) begin
      if (strobeHigh) begin
        {wrMasks[1], wrBeats[15:8]} <= {mem_mask_high, mem_data_in[15:8]};
      end else begin
        {wrMasks[3], wrBeats[31:24]} <= {mem_mask_high, mem_data_in[15:8]};
      end
    end
    lowSeen = strobeLow;
    highSeen = strobeHigh;
  end

  // ==========================================================
  // read answer: beat0 = address, beat1 = its inverse
  task automatic respond(input logic [15:0] addr);
    // start off the system clock edges so sampling never races the change
    #(slow ? 205 : 45);
    memData = addr;
    memStrobe = 1'b1;
    memDrive = 1'b1;
    #120;
    memData = ~addr;
    memStrobe = 1'b0;
    #120;
    memDrive = 1'b0;
  endtask

  always @(posedge mem_clk_true) begin
    if (mem_rank_sel_n != 2'h3 && !mute &&
      {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} == 3'h5) begin
      respond(mem_addr);
    end
  end
endmodule
`default_nettype wire

// ===== dv/ddr3_sdram_pin_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_sdram_pin_interface_bench;
  localparam logic [23:0] CODES = {3'h6, 3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h7};
  logic sys_clk, rst_n, cmdValid, cmdReady, cmdRank, clkEnable, termOn, mute, slow;
  ddr_pins_pkg::cmd_e cmdKind;
  logic [2:0] cmdBank, mem_bank;
  logic [15:0] cmdAddr, mem_addr, mem_data_in, mem_data_out;
  logic [31:0] wrData, rdData, wrBeats;
  logic [3:0] wrMask, wrMasks;
  logic rdValid, rdTimeout, mem_clk_true, mem_clk_comp, mem_clk_en, mem_term_ctrl;
  logic [1:0] mem_rank_sel_n;
  logic mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n, mem_data_oe_n;
  logic mem_mask_low, mem_mask_high, mem_strobe_oe_n;
  logic slti, slci, shti, shci, slto, slco, shto, shco;
  int errors = 0;
  int numChecks = 0;

  ddr_pin_interface dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdRank(cmdRank), .cmdBank(cmdBank),
    .cmdAddr(cmdAddr), .wrData(wrData), .wrMask(wrMask), .clkEnable(clkEnable),
    .termOn(termOn), .rdValid(rdValid), .rdData(rdData), .rdTimeout(rdTimeout),
    .mem_clk_true(mem_clk_true), .mem_clk_comp(mem_clk_comp), .mem_clk_en(mem_clk_en),
    .mem_rank_sel_n(mem_rank_sel_n), .mem_row_strobe_n(mem_row_strobe_n),
    .mem_col_strobe_n(mem_col_strobe_n), .mem_write_en_n(mem_write_en_n),
    .mem_bank(mem_bank), .mem_addr(mem_addr), .mem_term_ctrl(mem_term_ctrl),
    .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n),
    .mem_mask_low(mem_mask_low), .mem_mask_high(mem_mask_high),
    .mem_strobe_low_true_in(slti), .mem_strobe_low_comp_in(slci),
    .mem_strobe_high_true_in(shti), .mem_strobe_high_comp_in(shci),
    .mem_strobe_low_true_out(slto), .mem_strobe_low_comp_out(slco),
    .mem_strobe_high_true_out(shto), .mem_strobe_high_comp_out(shco),
    .mem_strobe_oe_n(mem_strobe_oe_n));

  ddr_mem_model memory (.mem_clk_true(mem_clk_true), .mem_rank_sel_n(mem_rank_sel_n),
    .mem_row_strobe_n(mem_row_strobe_n), .mem_col_strobe_n(mem_col_strobe_n),
    .mem_write_en_n(mem_write_en_n), .mem_addr(mem_addr), .mem_data_out(mem_data_out),
    .mem_data_oe_n(mem_data_oe_n), .mem_mask_low(mem_mask_low), .mem_mask_high(mem_mask_high),
    .mem_strobe_low_true_out(slto), .mem_strobe_low_comp_out(slco),
    .mem_strobe_high_true_out(shto), .mem_strobe_high_comp_out(shco),
    .mem_strobe_oe_n(mem_strobe_oe_n), .mem_data_in(mem_data_in),
    .mem_strobe_low_true_in(slti), .mem_strobe_low_comp_in(slci),
    .mem_strobe_high_true_in(shti), .mem_strobe_high_comp_in(shci),
    .mute(mute), .slow(slow), .wrBeats(wrBeats), .wrMasks(wrMasks));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic issue(input ddr_pins_pkg::cmd_e k, input logic r, input logic [2:0] b,
    input logic [15:0] a);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    check({31'h0, cmdReady}, 32'h1);
    cmdKind = k;
    {cmdValid, cmdRank, cmdBank, cmdAddr} = {1'b1, r, b, a};
    @(negedge sys_clk);
    cmdValid = 1'b0;
  endtask

  task automatic wait_answer;
    int n;
    n = 0;
    while (rdValid !== 1'b1 && rdTimeout !== 1'b1 && n < 120) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic reset_values;
    check({17'h0, mem_clk_true, mem_clk_comp, mem_clk_en, mem_rank_sel_n, mem_row_strobe_n,
      mem_col_strobe_n, mem_write_en_n, mem_term_ctrl, mem_data_oe_n, mem_strobe_oe_n,
      mem_mask_low, mem_mask_high, rdValid, rdTimeout}, 32'h4fb0);
    check({13'h0, mem_bank, mem_addr}, 32'h0);
  endtask

  task automatic levels;
    {clkEnable, termOn} = 2'b11;
    repeat (16) @(negedge sys_clk);
    check({30'h0, mem_clk_en, mem_term_ctrl}, 32'h3);
    {clkEnable, termOn} = 2'b00;
    repeat (16) @(negedge sys_clk);
    check({30'h0, mem_clk_en, mem_term_ctrl}, 32'h0);
    {clkEnable, termOn} = 2'b11;
    repeat (16) @(negedge sys_clk);
  endtask

  task automatic encode_all;
    for (int k = 1; k < 8; k++) begin
      issue(ddr_pins_pkg::cmd_e'(k), k[0], k[2:0], {k[2:0], 13'h0a5c});
      @(posedge mem_clk_true);
      #1;
      check({29'h0, mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n},
        32'(CODES[k*3 +: 3]));
      check({29'h0, mem_bank}, {29'h0, k[2:0]});
      check({16'h0, mem_addr}, {16'h0, k[2:0], 13'h0a5c});
      check({30'h0, mem_rank_sel_n}, {30'h0, ~(2'h1 << k[0])});
      check({29'h0, mem_clk_true, mem_clk_comp, mem_clk_en}, 32'h5);
      @(negedge sys_clk);
    end
    repeat (40) @(negedge sys_clk);
    check({27'h0, mem_rank_sel_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n},
      32'h1f);
  endtask

  task automatic write_burst;
    {wrData, wrMask} = {32'hc3a5_1e7f, 4'h9};
    issue(ddr_pins_pkg::CMD_WR, 1'b0, 3'h2, 16'h0040);
    repeat (16) @(negedge sys_clk);
    check(wrBeats, 32'hc3a5_1e7f);
    check({28'h0, wrMasks}, 32'h9);
  endtask

  task automatic read_timeout;
    mute = 1'b1;
    issue(ddr_pins_pkg::CMD_RD, 1'b0, 3'h7, 16'h0001);
    wait_answer();
    check({30'h0, rdValid, rdTimeout}, 32'h1);
    mute = 1'b0;
  endtask

  task automatic read_burst(input logic s, input logic [15:0] a);
    slow = s;
    issue(ddr_pins_pkg::CMD_RD, 1'b1, 3'h5, a);
    wait_answer();
    check({30'h0, rdValid, rdTimeout}, 32'h2);
    check(rdData, {~a, a});
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    {rst_n, cmdValid, cmdRank, cmdBank, cmdAddr, wrData, wrMask} = '0;
    {clkEnable, termOn, mute, slow} = 4'h0;
    cmdKind = ddr_pins_pkg::CMD_NOP;
    repeat (6) @(negedge sys_clk);
    reset_values();
    rst_n = 1'b1;
    levels();
    encode_all();
    write_burst();
    read_timeout();
    read_burst(1'b1, 16'hf00f);
    read_burst(1'b0, 16'h12ab);
    give_verdict();
  end

  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
